// >>> rtl/ascs_pkg.sv
package ascs_pkg;

    // Channel count and channel index width of the full variant
    localparam int          CH_COUNT        = 8;
    localparam int          CH_IDX_W        = 3;
    localparam int          ADDR_W          = 7;
    localparam int          DATA_W          = 8;

    // Register addresses on the register port
    localparam logic [6:0]  ADDR_SCAN_SEL   = 7'h01;
    localparam logic [6:0]  ADDR_FE_PD      = 7'h02;

    // Reset values
    localparam logic [7:0]  SCAN_SEL_RESET  = 8'hFF;
    localparam logic [7:0]  FE_PD_RESET     = 8'h00;
    localparam logic [7:0]  RDATA_RESET     = 8'h00;
    localparam logic [7:0]  UNMAPPED_RDATA  = 8'h00;
    localparam logic [2:0]  CHAN_RESET      = 3'h0;

    // Channel used when nothing is eligible
    localparam logic [2:0]  FALLBACK_CHAN   = 3'h0;
    localparam logic [2:0]  LAST_CHAN       = 3'h7;
    localparam logic [2:0]  CHAN_STEP       = 3'h1;

    // Whole state of the sequencer
    typedef struct packed {
        logic [7:0] scan_sel;
        logic [7:0] fe_pd;
        logic [2:0] chan;
        logic [7:0] rdata;
        logic       invalid;
    } ascs_state_s;

endpackage : ascs_pkg

// >>> rtl/ascs_sequencer.sv
`timescale 1ns/1ps
module ascs_sequencer #(
    parameter int NUM_CHANNELS = 8
) (
    input  wire logic        CLOCK_IN,
    input  wire logic        RESET_N_IN,
    input  wire logic        SOFT_RESET_IN,
    input  wire logic [6:0]  REG_ADDR_IN,
    input  wire logic        REG_WRITE_IN,
    input  wire logic [7:0]  REG_WDATA_IN,
    input  wire logic        REG_READ_IN,
    output logic      [7:0]  REG_RDATA_OUT,
    input  wire logic        AUTO_SCAN_IN,
    input  wire logic [2:0]  MANUAL_CHANNEL_IN,
    input  wire logic        CONV_START_IN,
    output logic      [2:0]  CHANNEL_OUT,
    output logic      [7:0]  FRONTEND_OFF_OUT,
    output logic             DATA_INVALID_OUT
);

    ascs_pkg::ascs_state_s state_reg;
    ascs_pkg::ascs_state_s state_next;
    logic [7:0]            chan_mask;
    logic [7:0]            eligible;
    logic [2:0]            scan_pick;

    // Implemented channels of this variant
    for (genvar g = 0; g < ascs_pkg::CH_COUNT; g++) begin : g_mask
        assign chan_mask[g] = (g < NUM_CHANNELS);
    end

    // Selected, powered and present channels only
    assign eligible = state_reg.scan_sel & ~state_reg.fe_pd & chan_mask;

    // Next channel above the current one, else wrap to the lowest
    function automatic logic [2:0] next_channel(input logic [7:0] elig,
                                                input logic [2:0] cur);
        logic [2:0] lowest;
        logic [2:0] above;
        logic       found;
        lowest = ascs_pkg::FALLBACK_CHAN;
        above  = ascs_pkg::FALLBACK_CHAN;
        found  = 1'h0;
        for (int i = ascs_pkg::CH_COUNT - 1; i >= 0; i--) begin
            if (elig[i]) begin
                lowest = 3'(i);
            end
            if (elig[i] && (3'(i) > cur)) begin
                above = 3'(i);
                found = 1'h1;
            end
        end
        // Empty set falls out as channel zero through lowest
        next_channel = found ? above : lowest;
    endfunction : next_channel

    assign scan_pick = next_channel(eligible, state_reg.chan);

    // Next-state logic for registers, channel pick and read data
    always_comb begin
        state_next = state_reg;
        if (SOFT_RESET_IN) begin
            // Commanded reset wins over a write in the same cycle
            state_next.scan_sel = ascs_pkg::SCAN_SEL_RESET;
            state_next.fe_pd    = ascs_pkg::FE_PD_RESET;
            state_next.chan     = ascs_pkg::CHAN_RESET;
        end else begin
            if (REG_WRITE_IN && (REG_ADDR_IN == ascs_pkg::ADDR_SCAN_SEL)) begin
                // Absent channels keep their reset value
                state_next.scan_sel = (REG_WDATA_IN & chan_mask)
                                    | (ascs_pkg::SCAN_SEL_RESET & ~chan_mask);
            end
            if (REG_WRITE_IN && (REG_ADDR_IN == ascs_pkg::ADDR_FE_PD)) begin
                state_next.fe_pd = (REG_WDATA_IN & chan_mask)
                                 | (ascs_pkg::FE_PD_RESET & ~chan_mask);
            end
            if (CONV_START_IN) begin
                // Picks from registers as they stand now
                state_next.chan = AUTO_SCAN_IN ? scan_pick : MANUAL_CHANNEL_IN;
            end
        end
        if (REG_READ_IN) begin
            if (REG_ADDR_IN == ascs_pkg::ADDR_SCAN_SEL) begin
                state_next.rdata = state_reg.scan_sel | ~chan_mask;
            end else if (REG_ADDR_IN == ascs_pkg::ADDR_FE_PD) begin
                state_next.rdata = state_reg.fe_pd | ~chan_mask;
            end else begin
                state_next.rdata = ascs_pkg::UNMAPPED_RDATA;
            end
        end
        // Only implemented channels count toward all-off
        state_next.invalid = &(state_next.fe_pd | ~chan_mask);
    end

    // State register
    always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            state_reg.scan_sel <= ascs_pkg::SCAN_SEL_RESET;
            state_reg.fe_pd    <= ascs_pkg::FE_PD_RESET;
            state_reg.chan     <= ascs_pkg::CHAN_RESET;
            state_reg.rdata    <= ascs_pkg::RDATA_RESET;
            state_reg.invalid  <= 1'h0;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs straight from flops
    assign REG_RDATA_OUT    = state_reg.rdata;
    assign CHANNEL_OUT      = state_reg.chan;
    assign FRONTEND_OFF_OUT = state_reg.fe_pd & chan_mask;
    assign DATA_INVALID_OUT = state_reg.invalid;

    // Checks
    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (!RESET_N_IN);

    sequence auto_conv_s;
        CONV_START_IN && AUTO_SCAN_IN && !SOFT_RESET_IN;
    endsequence

    sequence scan_write_s;
        REG_WRITE_IN && !SOFT_RESET_IN && (REG_ADDR_IN == ascs_pkg::ADDR_SCAN_SEL);
    endsequence

    sequence pd_write_s;
        REG_WRITE_IN && !SOFT_RESET_IN && (REG_ADDR_IN == ascs_pkg::ADDR_FE_PD);
    endsequence

    soft_reset_sel_a: assert property (SOFT_RESET_IN |=>
        state_reg.scan_sel == ascs_pkg::SCAN_SEL_RESET && CHANNEL_OUT == ascs_pkg::CHAN_RESET)
        else $error("scan select not restored by commanded reset");

    soft_reset_pd_a: assert property (SOFT_RESET_IN |=>
        FRONTEND_OFF_OUT == ascs_pkg::FE_PD_RESET && !DATA_INVALID_OUT)
        else $error("power-down not restored by commanded reset");

    empty_fallback_a: assert property (auto_conv_s and (eligible == 8'h00) |=>
        CHANNEL_OUT == ascs_pkg::FALLBACK_CHAN)
        else $error("empty scan set did not pick channel zero");

    ascend_step_a: assert property (auto_conv_s and (CHANNEL_OUT != ascs_pkg::LAST_CHAN)
        and eligible[3'(CHANNEL_OUT + ascs_pkg::CHAN_STEP)] |=>
        CHANNEL_OUT == 3'($past(CHANNEL_OUT) + ascs_pkg::CHAN_STEP))
        else $error("scan did not step to next channel");

    wrap_lowest_a: assert property (auto_conv_s and (eligible != 8'h00)
        and (((eligible >> CHANNEL_OUT) >> 1) == 8'h00) |=>
        CHANNEL_OUT <= $past(CHANNEL_OUT))
        else $error("scan did not wrap past highest channel");

    skip_powered_a: assert property (auto_conv_s and (eligible != 8'h00) |=>
        !FRONTEND_OFF_OUT[CHANNEL_OUT] && state_reg.scan_sel[CHANNEL_OUT])
        else $error("scan picked an ineligible channel");

    sel_write_a: assert property (scan_write_s |=>
        state_reg.scan_sel == ($past(REG_WDATA_IN) | ~chan_mask))
        else $error("scan select write wrong or absent bits changed");

    pd_write_a: assert property (pd_write_s |=>
        FRONTEND_OFF_OUT == ($past(REG_WDATA_IN) & chan_mask))
        else $error("power-down write not taken");

    read_ones_a: assert property (REG_READ_IN && (REG_ADDR_IN == ascs_pkg::ADDR_FE_PD) |=>
        REG_RDATA_OUT == ($past(state_reg.fe_pd) | ~chan_mask))
        else $error("power-down read data wrong");

    all_off_a: assert property (pd_write_s and (REG_WDATA_IN == 8'hFF) |=>
        DATA_INVALID_OUT ##1 (DATA_INVALID_OUT || $past(REG_WRITE_IN || SOFT_RESET_IN)))
        else $error("all front ends off not flagged invalid");

    manual_pick_a: assert property (CONV_START_IN && !AUTO_SCAN_IN && !SOFT_RESET_IN |=>
        CHANNEL_OUT == $past(MANUAL_CHANNEL_IN))
        else $error("manual conversion used wrong channel");

    // Register port checks; reads must never disturb state
    sequence sel_read_s;
        REG_READ_IN && (REG_ADDR_IN == ascs_pkg::ADDR_SCAN_SEL);
    endsequence

    sequence other_read_s;
        REG_READ_IN && (REG_ADDR_IN != ascs_pkg::ADDR_SCAN_SEL)
                    && (REG_ADDR_IN != ascs_pkg::ADDR_FE_PD);
    endsequence

    sequence quiet_conv_s;
        !CONV_START_IN && !SOFT_RESET_IN;
    endsequence

    // Read of scan select shows ones for absent channels
    read_sel_a: assert property (sel_read_s |=>
        REG_RDATA_OUT == ($past(state_reg.scan_sel) | ~chan_mask))
        else $error("scan select read data wrong");

    // Unmapped addresses read a fixed value
    read_unmapped_a: assert property (other_read_s |=>
        REG_RDATA_OUT == ascs_pkg::UNMAPPED_RDATA)
        else $error("unmapped read data wrong");

    // Read data stands until the next read
    rdata_hold_a: assert property (!REG_READ_IN |=>
        $stable(REG_RDATA_OUT))
        else $error("read data changed without a read");

    // Read and write together return the old value
    read_old_a: assert property (sel_read_s and scan_write_s |=>
        REG_RDATA_OUT == ($past(state_reg.scan_sel) | ~chan_mask))
        else $error("read beside write did not return old value");

    // Channel only moves on a conversion or reset
    chan_hold_a: assert property (quiet_conv_s |=>
        $stable(CHANNEL_OUT))
        else $error("channel moved without a conversion");

    // Scan select only changes on its own write or a commanded reset
    sel_hold_a: assert property (!(REG_WRITE_IN && (REG_ADDR_IN == ascs_pkg::ADDR_SCAN_SEL))
        && !SOFT_RESET_IN |=> $stable(state_reg.scan_sel))
        else $error("scan select changed without a write");

    // Power-down only changes on its own write or a commanded reset
    pd_hold_a: assert property (!(REG_WRITE_IN && (REG_ADDR_IN == ascs_pkg::ADDR_FE_PD))
        && !SOFT_RESET_IN |=> $stable(FRONTEND_OFF_OUT))
        else $error("power-down changed without a write");

    // Written bits of present channels land as written
    sel_write_full_a: assert property (scan_write_s |=>
        (state_reg.scan_sel & chan_mask) == ($past(REG_WDATA_IN) & chan_mask))
        else $error("scan select write not taken");

    // Absent channels keep their reset selection
    absent_sel_a: assert property (
        (state_reg.scan_sel & ~chan_mask) == (ascs_pkg::SCAN_SEL_RESET & ~chan_mask))
        else $error("absent channel selection changed");

    // Absent channels never hold a power-down bit
    absent_pd_a: assert property (
        (state_reg.fe_pd & ~chan_mask) == (ascs_pkg::FE_PD_RESET & ~chan_mask))
        else $error("absent channel power-down changed");

    // Invalid flag follows the power-down outputs exactly
    invalid_match_a: assert property (
        DATA_INVALID_OUT == &(FRONTEND_OFF_OUT | ~chan_mask))
        else $error("invalid flag disagrees with power-down");

    // A powered channel left means data is valid again
    pd_clear_a: assert property (pd_write_s and ((REG_WDATA_IN | ~chan_mask) != 8'hFF) |=>
        !DATA_INVALID_OUT)
        else $error("invalid flag set with a channel powered");

    // Scan pick is an eligible channel whenever one exists
    pick_eligible_a: assert property (auto_conv_s and (eligible != 8'h00) |=>
        (($past(eligible) >> CHANNEL_OUT) & 8'h01) != 8'h00)
        else $error("scan pick not eligible");

    // Scan never lands on an absent channel
    pick_present_a: assert property (auto_conv_s |=>
        chan_mask[CHANNEL_OUT])
        else $error("scan picked an absent channel");

    // Cleared select register alone forces channel zero
    empty_sel_a: assert property (auto_conv_s and (state_reg.scan_sel == 8'h00) |=>
        CHANNEL_OUT == ascs_pkg::FALLBACK_CHAN)
        else $error("cleared select did not pick channel zero");

    // With an eligible channel above, the scan climbs
    ascend_up_a: assert property (auto_conv_s
        and (((eligible >> CHANNEL_OUT) >> 1) != 8'h00) |=>
        CHANNEL_OUT > $past(CHANNEL_OUT))
        else $error("scan did not climb");

    // Climb goes to the nearest eligible channel, skipping none
    ascend_near_a: assert property (auto_conv_s
        and (((eligible >> CHANNEL_OUT) >> 1) != 8'h00) |=>
        ($past(eligible) & ~((8'h02 << $past(CHANNEL_OUT)) - 8'h01)
         & ((8'h01 << CHANNEL_OUT) - 8'h01)) == 8'h00)
        else $error("scan skipped an eligible channel");

    // Wrap lands on the lowest eligible channel
    wrap_min_a: assert property (auto_conv_s and (eligible != 8'h00)
        and (((eligible >> CHANNEL_OUT) >> 1) == 8'h00) |=>
        ($past(eligible) & ((8'h01 << CHANNEL_OUT) - 8'h01)) == 8'h00)
        else $error("wrap missed the lowest channel");

    // Conversions never touch power-down state
    conv_pd_a: assert property (CONV_START_IN && !REG_WRITE_IN && !SOFT_RESET_IN |=>
        $stable(FRONTEND_OFF_OUT))
        else $error("conversion changed power-down");

    // Commanded reset leaves read data alone
    soft_rdata_a: assert property (SOFT_RESET_IN && !REG_READ_IN |=>
        $stable(REG_RDATA_OUT))
        else $error("commanded reset changed read data");

endmodule : ascs_sequencer

// >>> bench/ascs_host_model.sv
`timescale 1ns/1ps
// Host controller on the register port; strobes move by non-blocking at an edge
module ascs_host_model (
    input  wire logic       clk_in,
    input  wire logic [7:0] rdata_in,
    output logic      [6:0] addr_out,
    output logic            write_out,
    output logic      [7:0] wdata_out,
    output logic            read_out
);
    // Idle port at time zero
    initial begin
        addr_out = 7'h00;
        write_out = 1'h0;
        wdata_out = 8'h00;
        read_out = 1'h0;
    end
    // Write; strobe is held for one clock cycle
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_out <= a;
        wdata_out <= d;
        write_out <= 1'h1;
        @(posedge clk_in);
        write_out <= 1'h0;
        wdata_out <= ~d; // Stale data is not left on the port
        #1;
    endtask : wr
    // Read; data is taken one cycle after the strobe edge
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        @(posedge clk_in);
        addr_out <= a;
        read_out <= 1'h1;
        @(posedge clk_in);
        read_out <= 1'h0;
        #1 d = rdata_in;
    endtask : rd
endmodule : ascs_host_model

// >>> bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic       clock, reset_n, soft_reset, auto_scan, conv_start, wr, rd, inv, inv4;
    logic [6:0] addr;
    logic [7:0] wdata, rdata, rdata4, fe, fe4, d;
    logic [2:0] man_ch, chan, chan4;
    int         num_errors = 0, checks = 0, cycles = 0;
    // Free-running 20 MHz clock
    initial begin
        clock = 1'h0;
        forever #25 clock = ~clock;
    end
    // Full and four-channel variants share all stimulus
    ascs_sequencer #(.NUM_CHANNELS(8)) ascs_sequencer_i (.CLOCK_IN(clock), .RESET_N_IN(reset_n),
        .SOFT_RESET_IN(soft_reset), .REG_ADDR_IN(addr), .REG_WRITE_IN(wr), .REG_WDATA_IN(wdata),
        .REG_READ_IN(rd), .REG_RDATA_OUT(rdata), .AUTO_SCAN_IN(auto_scan), .MANUAL_CHANNEL_IN(man_ch),
        .CONV_START_IN(conv_start), .CHANNEL_OUT(chan), .FRONTEND_OFF_OUT(fe), .DATA_INVALID_OUT(inv));
    ascs_sequencer #(.NUM_CHANNELS(4)) ascs_sequencer4_i (.CLOCK_IN(clock), .RESET_N_IN(reset_n),
        .SOFT_RESET_IN(soft_reset), .REG_ADDR_IN(addr), .REG_WRITE_IN(wr), .REG_WDATA_IN(wdata),
        .REG_READ_IN(rd), .REG_RDATA_OUT(rdata4), .AUTO_SCAN_IN(auto_scan), .MANUAL_CHANNEL_IN(man_ch),
        .CONV_START_IN(conv_start), .CHANNEL_OUT(chan4), .FRONTEND_OFF_OUT(fe4), .DATA_INVALID_OUT(inv4));
    ascs_host_model ascs_host_model_i (.clk_in(clock), .rdata_in(rdata), .addr_out(addr),
        .write_out(wr), .wdata_out(wdata), .read_out(rd));
    // Compare one byte-wide result
    task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : cmp
    // One conversion pulse, then the picked channel
    task automatic conv(input logic [2:0] e);
        @(posedge clock);
        conv_start <= 1'h1;
        @(posedge clock);
        conv_start <= 1'h0;
        #1 cmp("channel", {5'h00, e}, {5'h00, chan});
        cmp("channel4", {5'h00, e}, {5'h00, chan4});
    endtask : conv
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : test_done
    // Hang guard; the whole run is under fifty cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 2000) begin
            num_errors++;
            test_done();
        end
    end
    // Main sequence
    initial begin
        reset_n = 1'h0;
        soft_reset = 1'h0;
        auto_scan = 1'h1;
        man_ch = 3'h0;
        conv_start = 1'h0;
        repeat (6) @(posedge clock);
        reset_n <= 1'h1;
        ascs_host_model_i.rd(7'h01, d);
        cmp("scan_sel", 8'hFF, d);
        cmp("scan_sel4", 8'hFF, rdata4);
        ascs_host_model_i.rd(7'h02, d);
        cmp("powerdown", 8'h00, d);
        cmp("fe_off", 8'h00, fe);
        $display("test reset done");
        ascs_host_model_i.wr(7'h01, 8'h0A);
        conv(3'h1);
        conv(3'h3);
        conv(3'h1);
        ascs_host_model_i.wr(7'h02, 8'h02);
        ascs_host_model_i.rd(7'h02, d);
        cmp("powerdown", 8'h02, d);
        conv(3'h3);
        conv(3'h3);
        ascs_host_model_i.wr(7'h01, 8'h00);
        conv(3'h0);
        $display("test scan done");
        ascs_host_model_i.wr(7'h02, 8'hF0);
        cmp("fe_off", 8'hF0, fe);
        cmp("fe_off4", 8'h00, fe4);
        cmp("invalid4", 8'h00, {7'h00, inv4});
        ascs_host_model_i.rd(7'h02, d);
        cmp("powerdown4", 8'hF0, rdata4);
        ascs_host_model_i.wr(7'h02, 8'hFF);
        cmp("invalid", 8'h01, {7'h00, inv});
        ascs_host_model_i.rd(7'h03, d);
        cmp("unmapped", 8'h00, d);
        $display("test powerdown done");
        ascs_host_model_i.wr(7'h02, 8'h01);
        @(posedge clock);
        auto_scan <= 1'h0;
        man_ch <= 3'h5;
        conv(3'h5);
        @(posedge clock);
        soft_reset <= 1'h1;
        @(posedge clock);
        soft_reset <= 1'h0;
        #1 cmp("channel", 8'h00, {5'h00, chan});
        cmp("fe_off", 8'h00, fe);
        ascs_host_model_i.rd(7'h01, d);
        cmp("scan_sel", 8'hFF, d);
        $display("test soft reset done");
        test_done();
    end
endmodule : tb_top
